// *** hw/sacr_pkg.sv ***
// constants, types and helpers shared by the converter control design
// assumes a 100 MHz system clock and a host-driven serial clock
package sacr_pkg;

  // ==========================================================
  // widths
  localparam int RES_W = 8;
  localparam int CNT_W = 4;
  localparam int TMR_W = 12;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_US = 35;
  // pin sync and the state step come out of the conversion budget, so
  // the result is shown within the limit measured from the trigger fall
  localparam int SYNC_LAT = 3;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ - SYNC_LAT;
  localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYCLES - 1);

  // ==========================================================
  // reset values and word length
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 4'h8;

  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_DOWN  = 5'h01,
    ST_TRACK = 5'h02,
    ST_TRIG  = 5'h04,
    ST_CONV  = 5'h08,
    ST_READ  = 5'h10
  } sacr_state_t;

  typedef struct packed {
    sacr_state_t state;
    logic [TMR_W-1:0] timer;
    logic trig_s1;
    logic trig_s2;
    logic pd_s1;
    logic pd_s2;
    logic [RES_W-1:0] pos_s1;
    logic [RES_W-1:0] pos_s2;
    logic [RES_W-1:0] neg_s1;
    logic [RES_W-1:0] neg_s2;
    logic [RES_W-1:0] held_pos;
    logic [RES_W-1:0] held_neg;
    logic [CNT_W-1:0] gray_s1;
    logic [CNT_W-1:0] gray_s2;
    logic [CNT_W-1:0] base;
    logic [RES_W-1:0] result;
    logic dout;
    logic dout_oe;
    logic tracking;
    logic converting;
  } sacr_sys_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gray;
  } sacr_lnk_t;

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] sacr_bin2gray(
    input logic [CNT_W-1:0] b
  );
    sacr_bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] sacr_gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    sacr_gray2bin = b;
  endfunction

endpackage

// *** hw/sacr_link_if.sv ***
// carries the falling-edge count of the serial clock to the system side
// assumes the source runs on the serial clock and the sink resyncs it
`timescale 1ns/1ps
interface sacr_link_if;
  import sacr_pkg::*;
  logic [CNT_W-1:0] cnt_gray;
  modport src (output cnt_gray);
  modport dst (input cnt_gray);
endinterface

// *** hw/sacr_link_cnt.sv ***
// serial-clock side: counts falling edges of the host serial clock
// assumes the clock may stop between frames; only differences are used
`timescale 1ns/1ps
module sacr_link_cnt
  import sacr_pkg::*;
(
  // link clock and system reset
  input wire logic clk_link_i,
  input wire logic rst_i,
  // count towards the system side
  sacr_link_if.src lnk
);

  sacr_lnk_t r = '0;
  sacr_lnk_t next_r;

  // ==========================================================
  // edge counter, gray coded so the system side samples it safely
  always_comb begin
    next_r = r;
    next_r.rst_s1 = rst_i;
    next_r.rst_s2 = r.rst_s1;
    if (r.rst_s2) begin
      next_r.cnt = CNT_RST;
    end else begin
      next_r.cnt = r.cnt + 4'h1;
    end
    next_r.gray = sacr_bin2gray(next_r.cnt);
  end

  always_ff @(negedge clk_link_i) begin
    r <= next_r;
  end

  assign lnk.cnt_gray = r.gray;

endmodule

// *** hw/sacr_top.sv ***
// conversion sequencing and serial result readout of an 8-bit converter
// assumes host drives trigger, serial clock and power-down as plain pins;
// the analog inputs arrive as 8-bit codes relative to full scale
`timescale 1ns/1ps

// Notes on behaviour
// - no result bits are shifted while the trigger is high
// - output bit advances on each serial clock falling edge
// - output released when powered down or after all bits shifted
// - power-down pin is active low; low means shutdown
// - input tracked while acquiring; trigger fall holds the sample
// - sample-and-hold returns to tracking right after conversion
// - each result is an 8-bit word
// - negative input or negative difference gives code zero
// - three wires: trigger, serial clock in; three-state data out
// - output low while converting, done within 35 us, then MSB shown
// - MSB first, straight binary; released at eighth falling edge
// - power-down aborts conversion; host waits 35 us, clocks eight
module sacr_top
  import sacr_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // host pins
  input wire logic clk_link_i,
  input wire logic conversion_trigger_i,
  input wire logic power_down_n_i,
  // analog front end, as codes
  input wire logic [RES_W-1:0] in_pos_i,
  input wire logic [RES_W-1:0] in_neg_i,
  // serial result pin
  output logic dout_o,
  output logic dout_oe_o,
  // status
  output logic tracking_o,
  output logic converting_o
);

  sacr_link_if lnk ();

  sacr_link_cnt u_link (
    .clk_link_i(clk_link_i),
    .rst_i(rst_i),
    .lnk(lnk.src)
  );

  sacr_sys_t r;
  sacr_sys_t next_r;
  logic [CNT_W-1:0] cnt_now;
  logic [CNT_W-1:0] shifted;
  logic [RES_W-1:0] conv_word;

  // ==========================================================
  // helpers
  // clamps a negative difference to zero
  function automatic logic [RES_W-1:0] sacr_convert(
    input logic [RES_W-1:0] pos,
    input logic [RES_W-1:0] neg
  );
    logic [RES_W:0] diff;
    diff = {1'b0, pos} - {1'b0, neg};
    if (diff[RES_W]) begin
      sacr_convert = RESULT_RST;
    end else begin
      sacr_convert = diff[RES_W-1:0];
    end
  endfunction

  // msb first: bit index counts down from the top
  function automatic logic sacr_bit_at(
    input logic [RES_W-1:0] word,
    input logic [CNT_W-1:0] n
  );
    logic [2:0] idx;
    idx = 3'h7 - n[2:0];
    sacr_bit_at = word[idx];
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    cnt_now = sacr_gray2bin(r.gray_s2);
    shifted = cnt_now - r.base;
    conv_word = sacr_convert(r.held_pos, r.held_neg);

    // pin synchronisers
    next_r.trig_s1 = conversion_trigger_i;
    next_r.trig_s2 = r.trig_s1;
    next_r.pd_s1 = power_down_n_i;
    next_r.pd_s2 = r.pd_s1;
    next_r.pos_s1 = in_pos_i;
    next_r.pos_s2 = r.pos_s1;
    next_r.neg_s1 = in_neg_i;
    next_r.neg_s2 = r.neg_s1;
    next_r.gray_s1 = lnk.cnt_gray;
    next_r.gray_s2 = r.gray_s1;

    next_r.converting = 1'b0;
    next_r.tracking = 1'b1;

    case (r.state)
      ST_DOWN: begin
        next_r.dout_oe = 1'b0;
        next_r.dout = 1'b0;
        next_r.tracking = 1'b0;
        if (r.pd_s2) begin
          next_r.state = ST_TRACK;
        end
      end
      ST_TRACK: begin
        next_r.held_pos = r.pos_s2;
        next_r.held_neg = r.neg_s2;
        next_r.dout_oe = 1'b0;
        if (r.trig_s2) begin
          next_r.state = ST_TRIG;
          next_r.dout = 1'b0;
          next_r.dout_oe = 1'b1;
        end
      end
      ST_TRIG: begin
        next_r.held_pos = r.pos_s2;
        next_r.held_neg = r.neg_s2;
        next_r.dout = 1'b0;
        next_r.dout_oe = 1'b1;
        if (!r.trig_s2) begin
          // trigger fall: stop tracking, hold the sample
          next_r.state = ST_CONV;
          next_r.timer = CONV_LOAD;
          next_r.tracking = 1'b0;
          next_r.converting = 1'b1;
        end
      end
      ST_CONV: begin
        next_r.tracking = 1'b0;
        next_r.converting = 1'b1;
        next_r.dout = 1'b0;
        next_r.dout_oe = 1'b1;
        // edges during conversion are not counted as readout
        next_r.base = cnt_now;
        if (r.trig_s2) begin
          // a new trigger mid-conversion restarts; old result is lost
          next_r.state = ST_TRIG;
          next_r.converting = 1'b0;
          next_r.tracking = 1'b1;
        end else if (r.timer == '0) begin
          next_r.result = conv_word;
          next_r.dout = conv_word[RES_W-1];
          next_r.state = ST_READ;
          next_r.converting = 1'b0;
          next_r.tracking = 1'b1;
        end else begin
          next_r.timer = r.timer - 12'h001;
        end
      end
      ST_READ: begin
        next_r.held_pos = r.pos_s2;
        next_r.held_neg = r.neg_s2;
        if (r.trig_s2) begin
          next_r.state = ST_TRIG;
          next_r.dout = 1'b0;
          next_r.dout_oe = 1'b1;
        end else if (shifted >= BITS_PER_WORD) begin
          next_r.dout_oe = 1'b0;
          next_r.dout = 1'b0;
          next_r.state = ST_TRACK;
        end else begin
          next_r.dout = sacr_bit_at(r.result, shifted);
          next_r.dout_oe = 1'b1;
        end
      end
      default: begin
        next_r.state = ST_DOWN;
        next_r.dout_oe = 1'b0;
        next_r.tracking = 1'b0;
      end
    endcase

    // shutdown wins over everything and aborts a conversion at once
    if (!r.pd_s2) begin
      next_r.state = ST_DOWN;
      next_r.dout_oe = 1'b0;
      next_r.dout = 1'b0;
      next_r.tracking = 1'b0;
      next_r.converting = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r <= '0;
      r.state <= ST_DOWN;
      r.result <= RESULT_RST;
      r.base <= CNT_RST;
    end else begin
      r <= next_r;
    end
  end

  assign dout_o = r.dout;
  assign dout_oe_o = r.dout_oe;
  assign tracking_o = r.tracking;
  assign converting_o = r.converting;

endmodule

// *** dv/sacr_top_monitor.sv ***
// port checker for the converter readout top
// assumes a bind to sacr_top; the serial clock is seen through a toggle
`timescale 1ns/1ps
module sacr_top_monitor
  import sacr_pkg::*;
(
  // clocks and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  // pins and status
  input wire logic conversion_trigger_i,
  input wire logic power_down_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic tracking_o,
  input wire logic converting_o
);
  // ======
  // helpers
  // the serial high phase is shorter than a system period, so each
  // falling edge flips a bit that the system side can always see
  logic tog = 1'b0;
  logic [1:0] lk;
  logic [3:0] since;
  logic [3:0] nfall;
  logic [11:0] cyc;
  logic fall;
  assign fall = lk[1] ^ lk[0];
  always_ff @(negedge clk_link_i) begin
    tog <= ~tog;
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lk <= 2'h0;
      since <= 4'hf;
      nfall <= 4'h0;
      cyc <= 12'h000;
    end else begin
      lk <= {lk[0], tog};
      since <= fall ? 4'h0 : since + {3'h0, since != 4'hf};
      nfall <= (converting_o | conversion_trigger_i) ? 4'h0 :
        nfall + {3'h0, fall && nfall != 4'hf};
      cyc <= converting_o ? cyc + 12'h001 : 12'h000;
    end
  end
  // ======
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence s_done;
    $fell(converting_o) && power_down_n_i;
  endsequence
  sequence s_quiet;
    (!conversion_trigger_i && tracking_o && dout_oe_o) [*6];
  endsequence
  chk_conv_time: assert property (s_done |-> cyc == 12'(CONV_CYCLES))
    else $error("bad conversion time");
  chk_track_back: assert property (s_done |-> tracking_o)
    else $error("no tracking after conversion");
  chk_conv_low: assert property (converting_o |-> dout_oe_o && !dout_o)
    else $error("output not low while converting");
  chk_hold_on: assert property (converting_o |-> !tracking_o)
    else $error("tracking while converting");
  chk_trig_quiet: assert property (
    (conversion_trigger_i && power_down_n_i) [*5] |-> !dout_o)
    else $error("bit shifted with trigger high");
  chk_bit_step: assert property (
    s_quiet ##0 $changed(dout_o) |-> since < 4'h8)
    else $error("bit moved without serial fall");
  chk_oe_off: assert property (
    nfall >= 4'h8 && since > 4'h5 |-> !dout_oe_o)
    else $error("output kept after eight bits");
  chk_pd_off: assert property (
    !power_down_n_i [*4] |-> !dout_oe_o && !converting_o)
    else $error("active in power-down");
endmodule
bind sacr_top sacr_top_monitor u_sacr_top_monitor (.*);

// *** dv/sacr_host_model.sv ***
// host model: trigger, serial clock and power-down pins
// assumes line_i is the resolved data wire; serial clock idles low
`timescale 1ns/1ps
module sacr_host_model (
  // clock and data wire
  input wire logic clk_sys_i,
  input wire logic line_i,
  // host pins
  output logic conversion_trigger_o,
  output logic clk_link_o,
  output logic power_down_n_o
);
  // ======
  // pin tasks
  initial begin
    conversion_trigger_o = 1'b0;
    clk_link_o = 1'b0;
    power_down_n_o = 1'b1;
  end
  // caller leaves the conversion time before reading
  task automatic convert();
    @(negedge clk_sys_i);
    conversion_trigger_o = 1'b1;
    repeat (100) @(negedge clk_sys_i);
    conversion_trigger_o = 1'b0;
  endtask
  // one short burst per bit; the idle gap keeps the rate under 2 MHz
  task automatic read(output logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      #6 clk_link_o = 1'b1;
      w[i] = line_i;
      #6 clk_link_o = 1'b0;
      repeat (50) @(negedge clk_sys_i);
    end
  endtask
  task automatic power(input logic on);
    @(negedge clk_sys_i);
    power_down_n_o = on;
  endtask
endmodule

// *** dv/sacr_top_tb.sv ***
// self-checking bench for the converter readout top
// assumes the host model drives all host pins; data wire resolved here
`timescale 1ns/1ps
module sacr_top_tb;
  import sacr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [RES_W-1:0] in_pos_i = 8'h00;
  logic [RES_W-1:0] in_neg_i = 8'h00;
  logic flip = 1'b0;
  logic clk_link_i;
  logic conversion_trigger_i;
  logic power_down_n_i;
  logic dout_o;
  logic dout_oe_o;
  logic tracking_o;
  logic converting_o;
  logic line;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // ======
  // harness
  // a released wire has no pull, so it shows a changing level
  assign line = dout_oe_o ? dout_o : flip;
  always #5 clk_sys_i = ~clk_sys_i;
  sacr_top u_sacr_top (.*);
  sacr_host_model u_sacr_host_model (.clk_sys_i(clk_sys_i), .line_i(line),
    .conversion_trigger_o(conversion_trigger_i),
    .clk_link_o(clk_link_i), .power_down_n_o(power_down_n_i));
  always @(posedge clk_sys_i) begin
    flip <= ~flip;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ======
  // scenarios
  task automatic t_conv(logic [7:0] p, logic [7:0] n, logic [7:0] e);
    logic [7:0] w;
    in_pos_i = p;
    in_neg_i = n;
    u_sacr_host_model.convert();
    repeat (10) @(negedge clk_sys_i);
    check("busy", 8'h2, {6'h0, converting_o, tracking_o});
    check("held low", 8'h1, {7'h0, dout_oe_o & ~dout_o});
    in_pos_i = ~p;
    // 3500 cycles after the trigger fall the msb must already stand
    repeat (3490) @(negedge clk_sys_i);
    check("tracking", 8'h1, {7'h0, tracking_o});
    check("msb shown", {6'h0, 1'b1, e[7]},
      {5'h0, converting_o, dout_oe_o, dout_o});
    u_sacr_host_model.read(w);
    check("word", e, w);
    check("released", 8'h0, {7'h0, dout_oe_o});
    u_sacr_host_model.read(w);
    check("stays off", 8'h0, {7'h0, dout_oe_o});
  endtask
  task automatic t_pd();
    logic [7:0] w;
    u_sacr_host_model.convert();
    repeat (100) @(negedge clk_sys_i);
    u_sacr_host_model.power(1'b0);
    repeat (5) @(negedge clk_sys_i);
    check("pd off", 8'h0, {6'h0, dout_oe_o, converting_o});
    u_sacr_host_model.power(1'b1);
    repeat (3520) @(negedge clk_sys_i);
    u_sacr_host_model.read(w);
    check("pd idle", 8'h1, {6'h0, dout_oe_o, tracking_o});
  endtask
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    check("idle", 8'h1, {6'h0, dout_oe_o, tracking_o});
    t_conv(8'ha5, 8'h00, 8'ha5);
    t_conv(8'h80, 8'h30, 8'h50);
    t_conv(8'h10, 8'h20, 8'h00);
    t_pd();
    t_conv(8'hff, 8'h00, 8'hff);
    finish_test();
  end
endmodule
